// *** verilog/ifb_pkg.sv ***
package ifb_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ST_W = 5;

  // ==========================================================================
  // Register byte addresses, one aligned word each
  localparam logic [4:0] OFS_FLAG2 = 5'h00;
  localparam logic [4:0] OFS_FLAG3 = 5'h04;
  localparam logic [4:0] OFS_FLAG4 = 5'h08;
  localparam logic [4:0] OFS_EN0 = 5'h0c;
  localparam logic [4:0] OFS_EN1 = 5'h10;
  localparam logic [4:0] OFS_IRQ_ST = 5'h14;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
  localparam logic [4:0] OFS_IRQ_EN = 5'h1c;

  // ==========================================================================
  // Implemented bit positions of each bank
  localparam logic [15:0] MASK_FLAG2 = 16'h0007;
  localparam logic [15:0] MASK_FLAG3 = 16'h21ff;
  localparam logic [15:0] MASK_FLAG4 = 16'h00f6;
  localparam logic [15:0] MASK_EN0 = 16'h7fff;
  localparam logic [15:0] MASK_EN1 = 16'hfffb;

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [4:0] RST_ST = 5'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic [15:0] RD_PAD = 16'h0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status bit positions: a new request appeared in that group.
  localparam int ST_F2 = 0;
  localparam int ST_F3 = 1;
  localparam int ST_F4 = 2;
  localparam int ST_E0 = 3;
  localparam int ST_E1 = 4;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] f4;
    logic [15:0] f3;
    logic [15:0] f2;
  } ifb_flag_t;

  typedef struct packed {
    logic [15:0] e1;
    logic [15:0] e0;
  } ifb_en_t;

endpackage

// *** verilog/ifb_bank.sv ***
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// RQ1: A flag bit reads 1 once its source raised a request and 0 while none has occurred.
// RQ2: An enable bit at 1 passes its source's request on and at 0 blocks it.
// RQ3: Unimplemented bits of every bank read as zero and ignore writes.
// RQ4: Every implemented flag and enable bit clears to zero at power-on reset.
// RQ5: Every implemented flag and enable bit is readable and writable by software.
// RQ6: Flag bank 2 bit 2 is CAN 1 receive ready, bit 1 SPI 2 event, bit 0 SPI 2 error.
// RQ7: Flag bank 3 bit 13 is DMA 5 done and bit 8 CAN 2 event; bits 15-14 and 12-9 are absent.
// RQ8: Flag bank 3 bits 7 to 0 are CAN 2 rx, ext 4, ext 3, timer 9, timer 8, I2C 2 master,
//      I2C 2 slave, timer 7.
// RQ9: Flag bank 4 bits 15-8, 3 and 0 are absent; bits 7 to 4 are CAN 2 tx, CAN 1 tx, DMA 7, DMA 6.
// RQ10: Flag bank 4 bit 2 is serial 2 error and bit 1 serial 1 error.
// RQ11: Enable bank 0 bit 15 is absent; bits 14 to 8 enable DMA 1, converter 1, serial 1 tx,
//       serial 1 rx, SPI 1 event, SPI 1 error, timer 3.
// RQ12: Enable bank 0 bits 7 to 0 enable timer 2, compare 2, capture 2, DMA 0, timer 1,
//       compare 1, capture 1, ext 0.
// RQ13: Enable bank 1 bits 15 to 8 enable serial 2 tx, serial 2 rx, ext 2, timer 5, timer 4,
//       compare 4, compare 3, DMA 2.
// RQ14: Enable bank 1 bits 7 to 0 are capture 8, capture 7, converter 2, ext 1, change notify,
//       absent, I2C 1 master, I2C 1 slave.
// RQ15: A request goes to the processor only while both its flag and its enable are 1.
// RQ16: A flag is set by its event and held until software writes 0; a set wins over a clear.
module ifb_bank
  import ifb_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Event sources and the neighbouring banks
  input wire ifb_flag_t flag_event,
  input wire ifb_flag_t ext_enable,
  input wire ifb_en_t ext_flag,
  // Requests toward the processor
  output ifb_flag_t flag_req,
  output ifb_en_t enable_req,
  output logic irq
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m[7:0] = be[0] ? wd[7:0] : old[7:0];
    m[15:8] = be[1] ? wd[15:8] : old[15:8];
    return m & mask;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_FLAG2, OFS_FLAG3, OFS_FLAG4, OFS_EN0, OFS_EN1,
      OFS_IRQ_ST, OFS_IRQ_CLR, OFS_IRQ_EN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic any_new(input logic [15:0] nxt, input logic [15:0] cur);
    return |(nxt & ~cur);
  endfunction

  // ==========================================================================
  // State
  ifb_flag_t flag_q;
  ifb_flag_t flag_d;
  ifb_en_t en_q;
  ifb_en_t en_d;
  ifb_flag_t freq_q;
  ifb_flag_t freq_d;
  ifb_en_t ereq_q;
  ifb_en_t ereq_d;
  logic [ST_W-1:0] st_q;
  logic [ST_W-1:0] st_d;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] ien_q;
  logic irq_q;
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] resp_q;
  logic [15:0] rd_val;
  logic take;
  logic wr_go;
  logic [15:0] wd16;
  logic [1:0] be16;

  // ==========================================================================
  // Bus slave
  // A request is answered one edge after it is seen: waitrequest drops for one cycle and
  // the write lands at the edge where the master sees it low.
  assign take = ce && (avs_read || avs_write) && !wait_q;
  assign wr_go = take && avs_write && is_mapped(avs_address);
  assign wd16 = avs_writedata[15:0];
  assign be16 = avs_byteenable[1:0];

  always_comb begin
    case (avs_address)
      OFS_FLAG2: rd_val = flag_q.f2; // see RQ5
      OFS_FLAG3: rd_val = flag_q.f3;
      OFS_FLAG4: rd_val = flag_q.f4;
      OFS_EN0: rd_val = en_q.e0;
      OFS_EN1: rd_val = en_q.e1;
      OFS_IRQ_ST: rd_val = {11'h000, st_q};
      OFS_IRQ_EN: rd_val = {11'h000, ien_q};
      default: rd_val = RD_PAD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= RST_RDATA;
      resp_q <= RESP_OK;
    end else if (ce) begin
      if (take) begin
        wait_q <= 1'b1;
      end else if (avs_read || avs_write) begin
        wait_q <= 1'b0;
        rdata_q <= avs_read ? {RD_PAD, rd_val} : RST_RDATA;
        resp_q <= is_mapped(avs_address) ? RESP_OK : RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Flag and enable banks
  always_comb begin
    flag_d = flag_q;
    en_d = en_q;
    if (wr_go) begin
      case (avs_address)
        OFS_FLAG2: flag_d.f2 = wr_merge(flag_q.f2, wd16, be16, MASK_FLAG2); // see RQ6
        OFS_FLAG3: flag_d.f3 = wr_merge(flag_q.f3, wd16, be16, MASK_FLAG3); // see RQ7
        OFS_FLAG4: flag_d.f4 = wr_merge(flag_q.f4, wd16, be16, MASK_FLAG4); // see RQ9
        OFS_EN0: en_d.e0 = wr_merge(en_q.e0, wd16, be16, MASK_EN0); // see RQ11
        OFS_EN1: en_d.e1 = wr_merge(en_q.e1, wd16, be16, MASK_EN1); // see RQ13
        default: begin
        end
      endcase
    end
    // Events are ORed after the software write so that a set beats a same-cycle clear.
    flag_d.f2 = (flag_d.f2 | flag_event.f2) & MASK_FLAG2; // see RQ16
    flag_d.f3 = (flag_d.f3 | flag_event.f3) & MASK_FLAG3; // see RQ8
    flag_d.f4 = (flag_d.f4 | flag_event.f4) & MASK_FLAG4; // see RQ10
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= {RST_REG, RST_REG, RST_REG}; // see RQ4
      en_q <= {RST_REG, RST_REG};
    end else if (ce) begin
      flag_q <= flag_d; // see RQ1
      en_q <= en_d; // see RQ3
    end
  end

  // ==========================================================================
  // Requests toward the processor
  always_comb begin
    freq_d.f2 = flag_q.f2 & ext_enable.f2; // see RQ15
    freq_d.f3 = flag_q.f3 & ext_enable.f3;
    freq_d.f4 = flag_q.f4 & ext_enable.f4;
    ereq_d.e0 = ext_flag.e0 & en_q.e0; // see RQ2
    ereq_d.e1 = ext_flag.e1 & en_q.e1; // see RQ14
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_q <= {RST_REG, RST_REG, RST_REG};
      ereq_q <= {RST_REG, RST_REG};
    end else if (ce) begin
      freq_q <= freq_d;
      ereq_q <= ereq_d;
    end
  end

  // ==========================================================================
  // Summary interrupt
  // Each group posts a sticky status bit when a request newly appears in it.
  always_comb begin
    st_set[ST_F2] = any_new(freq_d.f2, freq_q.f2);
    st_set[ST_F3] = any_new(freq_d.f3, freq_q.f3);
    st_set[ST_F4] = any_new(freq_d.f4, freq_q.f4);
    st_set[ST_E0] = any_new(ereq_d.e0, ereq_q.e0);
    st_set[ST_E1] = any_new(ereq_d.e1, ereq_q.e1);
    st_d = st_q;
    if (wr_go && avs_address == OFS_IRQ_CLR && be16[0]) begin
      st_d = st_q & ~wd16[ST_W-1:0];
    end
    st_d = st_d | st_set;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= RST_ST;
      ien_q <= RST_ST;
      irq_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      if (wr_go && avs_address == OFS_IRQ_EN && be16[0]) begin
        ien_q <= wd16[ST_W-1:0];
      end
      irq_q <= |(st_q & ien_q);
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_response = resp_q;
  assign flag_req = freq_q;
  assign enable_req = ereq_q;
  assign irq = irq_q;

  // ==========================================================================
  // Checks
  logic first_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_q <= 1'b0;
    end else begin
      first_q <= 1'b1;
    end
  end

  sequence s_wr_full(logic [4:0] a);
    ce && avs_write && !wait_q && avs_address == a && avs_byteenable[1:0] == 2'h3;
  endsequence

  sequence s_no_event;
    flag_event == '0;
  endsequence

  a_reset_clear: assert property (@(posedge clk) disable iff (!rst_b) // see RQ4
    !first_q |-> (flag_q == '0 && en_q == '0))
    else $error("banks not clear after reset");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_b) // see RQ3
    ((flag_q.f3 & ~MASK_FLAG3) == '0) && ((flag_q.f4 & ~MASK_FLAG4) == '0)
    && ((en_q.e1 & ~MASK_EN1) == '0) && ((flag_q.f2 & ~MASK_FLAG2) == '0)
    && ((en_q.e0 & ~MASK_EN0) == '0))
    else $error("unimplemented bit set");

  a_event_sets: assert property (@(posedge clk) disable iff (!rst_b) // see RQ16
    (ce && flag_event.f3[8]) |=> flag_q.f3[8] ##1 (!ce || flag_q.f3[8]))
    else $error("event did not set flag");

  a_flag_write: assert property (@(posedge clk) disable iff (!rst_b) // see RQ5
    (s_wr_full(OFS_FLAG4) and s_no_event) |=> flag_q.f4 == ($past(wd16) & MASK_FLAG4))
    else $error("flag bank write lost");

  a_en_write: assert property (@(posedge clk) disable iff (!rst_b) // see RQ11
    s_wr_full(OFS_EN0) |=> en_q.e0 == ($past(wd16) & MASK_EN0))
    else $error("enable bank write lost");

  a_en_gate: assert property (@(posedge clk) disable iff (!rst_b) // see RQ2
    (ce && en_q.e1 == '0) |=> enable_req.e1 == '0)
    else $error("request passed while disabled");

  a_req_and: assert property (@(posedge clk) disable iff (!rst_b) // see RQ15
    ce |=> flag_req.f3 == $past(flag_q.f3 & ext_enable.f3))
    else $error("request not flag and enable");

  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && (avs_read || avs_write) && wait_q) ##1 ce |-> !wait_q ##1 (!ce || wait_q))
    else $error("bus answer timing wrong");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> irq == $past(|(st_q & ien_q)))
    else $error("interrupt output wrong");

  // ==========================================================================
  // Further checks
  // A frozen clock enable must hold every register, or a stalled system would lose events
  // that it never saw.
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> (flag_q == $past(flag_q)) && (en_q == $past(en_q)) && (st_q == $past(st_q)))
    else $error("state moved while frozen");

  a_set_wins: assert property (@(posedge clk) disable iff (!rst_b) // see RQ16
    (ce && flag_event.f2[1]) |=> flag_q.f2[1])
    else $error("event lost against clear");

  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_b) // see RQ1
    (wr_go && avs_address == OFS_FLAG2 && be16[0] && !wd16[0] && !flag_event.f2[0])
    |=> !flag_q.f2[0])
    else $error("flag not cleared by write");

  a_flag3_write: assert property (@(posedge clk) disable iff (!rst_b) // see RQ7
    (s_wr_full(OFS_FLAG3) and s_no_event) |=> flag_q.f3 == ($past(wd16) & MASK_FLAG3))
    else $error("flag bank 3 write lost");

  a_en1_write: assert property (@(posedge clk) disable iff (!rst_b) // see RQ13
    s_wr_full(OFS_EN1) |=> en_q.e1 == ($past(wd16) & MASK_EN1))
    else $error("enable bank 1 write lost");

  a_enreq_and: assert property (@(posedge clk) disable iff (!rst_b) // see RQ2
    ce |=> enable_req.e0 == $past(ext_flag.e0 & en_q.e0))
    else $error("enable request not flag and enable");

  // Status bits are sticky: only a clear write may drop them.
  a_st_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && st_q[ST_F3] && !(wr_go && avs_address == OFS_IRQ_CLR)) |=> st_q[ST_F3])
    else $error("status bit dropped by itself");

  a_slverr_ans: assert property (@(posedge clk) disable iff (!rst_b) // see RQ3
    (ce && (avs_read || avs_write) && wait_q && !is_mapped(avs_address))
    |=> avs_response == RESP_SLVERR)
    else $error("unmapped access not refused");

  a_rd_upper: assert property (@(posedge clk) disable iff (!rst_b) // see RQ3
    avs_readdata[31:16] == RD_PAD)
    else $error("upper read half not zero");

  // Without a request the slave must keep waitrequest high, so no stray answer is seen.
  a_wait_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !avs_read && !avs_write && wait_q) |=> wait_q)
    else $error("answer without request");

endmodule

// *** tb/ifb_src_model.sv ***
`timescale 1ns/10ps

// ====================
// Event sources
module ifb_src_model
  import ifb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Commands from the bench
  input wire logic go,
  input wire ifb_flag_t pulse,
  input wire ifb_flag_t hold,
  // Event lines into the bank
  output ifb_flag_t flag_event
);
  // Sources change their lines only on the clock, as real peripherals would.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_event <= '0;
    end else begin
      flag_event <= go ? (pulse | hold) : hold;
    end
  end
endmodule

// *** tb/ifb_bank_bench.sv ***
`timescale 1ns/10ps

// ====================
// Bench top
module ifb_bank_bench
  import ifb_pkg::*;
;
  logic clk, rst_b, ce, rd, wr, go, wq, irq;
  logic [4:0] adr;
  logic [31:0] wd, rdata, q;
  logic [3:0] be;
  logic [1:0] resp, rs;
  ifb_flag_t fev, eenb, pulse, hold, freq;
  ifb_en_t eflg, ereq;
  int errors, check_count;
  localparam logic [4:0] ofs [5] = '{OFS_FLAG2, OFS_FLAG3, OFS_FLAG4, OFS_EN0, OFS_EN1};
  localparam logic [15:0] msk [5] = '{MASK_FLAG2, MASK_FLAG3, MASK_FLAG4, MASK_EN0, MASK_EN1};

  ifb_bank DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wq), .avs_response(resp), .flag_event(fev), .ext_enable(eenb),
    .ext_flag(eflg), .flag_req(freq), .enable_req(ereq), .irq(irq));
  ifb_src_model src (.clk(clk), .rst_b(rst_b), .go(go), .pulse(pulse), .hold(hold),
    .flag_event(fev));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ====================
  // Tasks
  task chk(input logic [80:0] seen, input logic [80:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases it.
  task bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {16'h0000, d};
    @(posedge clk);
    while (wq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) errors++;
    q = rdata;
    rs = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    chk({rs, q}, {RESP_OK, e});
  endtask

  task fire(input ifb_flag_t v);
    @(posedge clk);
    go <= 1'b1;
    pulse <= v;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task settle;
    repeat (2) @(posedge clk);
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ====================
  // Tests
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wd = '0;
    be = 4'hf;
    go = 1'b0;
    pulse = '0;
    hold = '0;
    eenb = '0;
    eflg = '0;
    errors = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    chk({irq, freq, ereq}, '0);
    for (int i = 0; i < 5; i++) rdc(ofs[i], 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ofs[i], 16'hffff);
      rdc(ofs[i], {16'h0000, msk[i]});
      bus(1'b1, ofs[i], 16'h0000);
      rdc(ofs[i], 32'h0);
    end
    $display("test access done");
    for (int i = 0; i < 3; i++) begin
      fire(48'hffff << (16 * i));
      rdc(ofs[i], {16'h0000, msk[i]});
    end
    $display("test events done");
    eenb <= 48'h00a5_5a5a_ffff;
    bus(1'b1, OFS_EN0, 16'h1234);
    bus(1'b1, OFS_EN1, 16'hffff);
    eflg <= 32'h0f0f_00ff;
    repeat (3) @(posedge clk);
    chk(freq, 48'h00a4_005a_0007);
    chk(ereq, 32'h0f0b_0034);
    $display("test gating done");
    // A held event must beat the software clear landing in the same cycle.
    hold <= 48'h0000_0000_0002;
    bus(1'b1, OFS_FLAG2, 16'h0000);
    hold <= '0;
    settle;
    rdc(OFS_FLAG2, 32'h2);
    $display("test precedence done");
    bus(1'b1, OFS_FLAG3, 16'h0000);
    bus(1'b1, OFS_IRQ_CLR, 16'h001f);
    rdc(OFS_IRQ_ST, 32'h0);
    bus(1'b1, OFS_IRQ_EN, 16'h0002);
    settle;
    chk(irq, 1'b0);
    fire(48'h0000_0040_0000);
    rdc(OFS_IRQ_ST, 32'h2);
    chk(irq, 1'b1);
    bus(1'b1, OFS_IRQ_EN, 16'h0000);
    settle;
    chk(irq, 1'b0);
    bus(1'b1, OFS_IRQ_EN, 16'h0002);
    settle;
    chk(irq, 1'b1);
    bus(1'b1, OFS_IRQ_CLR, 16'h0002);
    settle;
    chk(irq, 1'b0);
    rdc(OFS_IRQ_CLR, 32'h0);
    bus(1'b1, OFS_IRQ_ST, 16'h001f);
    rdc(OFS_IRQ_ST, 32'h0);
    $display("test interrupt done");
    // Events arriving while the clock enable is low must not be taken.
    bus(1'b1, OFS_FLAG2, 16'h0000);
    ce <= 1'b0;
    hold <= 48'h0000_0000_0001;
    repeat (3) @(posedge clk);
    hold <= '0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rdc(OFS_FLAG2, 32'h0);
    $display("test freeze done");
    bus(1'b0, 5'h1e, 16'h0000);
    chk({rs, q}, {RESP_SLVERR, 32'h0});
    $display("test unmapped done");
    give_verdict;
  end

  // The full sequence needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule
